// [hmc_mode_ctrl.sv]
/*
 * Host-side mode control word of the network controller, with the
 * parallel host bus front end that it steers.
 * Assumes asynchronous host pins, a same-clock core that answers a read
 * strobe one cycle later, and a MAC that reports pause state as a level.
 */
// Function
// R01: bus width latched from strap, read-only
// R02: pause flag shows received pause frame
// R03: transmission held off while pause flag set
// R04: write data fetched after programmed delay
// R05: early chip select release fetches immediately
// R06: read data held two cycles if enabled
// R07: host avoids bus during read hold
// R08: fifo swap exchanges bytes on data ports
// R09: soft reset bit resets device, self-clears
// R10: normal mode: tx write-only, rx read-only
// R11: memory test allows both directions everywhere
// R12: host resets or closes socket after test
// R13: mode word resets to 3800 or b800
// R14: ping block stops automatic echo replies
// R15: pppoe enable bit drives pppoe operation
// R16: bus swap on all registers, wide only
// R17: bit zero selects indirect addressing
// R18: read-only and reserved writes ignored, zero
`default_nettype none
`include "hmc_defs.svh"

module hmc_mode_ctrl
  import hmc_pkg::*;
(
  input  wire logic              clk,           // core clock, 50 MHz
  input  wire logic              rst_n,         // sync reset, active low
  input  wire logic              hostCsN,       // host chip select
  input  wire logic              hostWrN,       // host write strobe
  input  wire logic              hostRdN,       // host read strobe
  input  wire hmc_pkg::hmc_word_t hostAddr,     // host address pins
  input  wire hmc_pkg::hmc_word_t hostDataIn,   // data pins, input side
  output var  hmc_pkg::hmc_word_t hostDataOut,  // data pins, output side
  output var  logic              hostDataOe,    // data pins driven
  input  wire logic              wideBusStrap,  // wide bus strap pin
  input  wire logic              pauseFrameRx,  // mac pause state
  input  wire hmc_pkg::hmc_word_t coreRdData,   // core read answer
  output var  logic              coreWrStb,     // core write pulse
  output var  logic              coreRdStb,     // core read pulse
  output var  hmc_pkg::hmc_word_t coreAddr,     // core address
  output var  hmc_pkg::hmc_word_t coreWrData,   // core write data
  output var  logic [1:0]        coreByteEn,    // core byte lanes
  output var  logic              coreSoftReset, // device soft reset
  output var  logic              txPause,       // hold off transmit
  output var  logic              pingBlock,     // no auto echo reply
  output var  logic              pppoeEnable,   // pppoe mode
  output var  logic              indirectMode,  // pointer addressing
  output var  logic              memTestEnable, // memory test path
  output var  logic              busWide        // 16-bit host bus
);
  import hmc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic hmc_word_t swapBytes(input hmc_word_t w);
    return {w[7:0], w[15:8]};
  endfunction : swapBytes

  function automatic logic isModeAddr(input hmc_word_t a);
    return (a & `HMC_EVEN_MASK) == `HMC_MODE_OFS;
  endfunction : isModeAddr

  function automatic logic isPortAddr(input hmc_word_t a, input logic [5:0] ofs);
    return ((a & `HMC_SOCK_MASK) == `HMC_SOCK_BASE) && ((a[5:0] & `HMC_PORT_MASK) == ofs);
  endfunction : isPortAddr

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [35:0] pinS;

  hmc_sync #(.W(36)) uSync (
    .clk (clk),
    .d   ({hostCsN, hostWrN, hostRdN, wideBusStrap, hostAddr, hostDataIn}),
    .q   (pinS)
  );

  wire       csNS    = pinS[35];
  wire       wrNS    = pinS[34];
  wire       rdNS    = pinS[33];
  wire       strapS  = pinS[32];
  hmc_word_t addrS;
  hmc_word_t dataS;
  assign addrS = pinS[31:16];
  assign dataS = pinS[15:0];

  // ****************************************************************
  // state
  // ****************************************************************
  hmc_state_t state_q;
  logic       csNPrev_q;
  logic       strapDone_q;
  logic       width_q;
  logic       pause_q;
  hmc_word_t  mode_q;
  hmc_word_t  addr_q;
  logic       rdPend_q;
  logic       rdTake_q;
  logic [1:0] holdCnt_q;
  logic [3:0] srstCnt_q;
  logic       fetch;

  wire csFall = csNPrev_q && !csNS;
  wire csRise = !csNPrev_q && csNS;

  hmc_fetch uFetch (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (csFall && !wrNS),
    .csHigh (csNS),
    .delay  (mode_q[`HMC_BIT_WRF_HI:`HMC_BIT_WRF_LO]),
    .fetch  (fetch)
  );

  // ****************************************************************
  // access decode
  // ****************************************************************
  wire fsOn    = mode_q[`HMC_BIT_FS];
  wire mtOn    = mode_q[`HMC_BIT_MT];
  wire rdhOn   = mode_q[`HMC_BIT_RDH];
  wire dbsOn   = mode_q[`HMC_BIT_DBS] && width_q;                  // R16
  wire isMode  = isModeAddr(addr_q);
  wire isTx    = isPortAddr(addr_q, `HMC_TX_PORT_OFS);
  wire isRx    = isPortAddr(addr_q, `HMC_RX_PORT_OFS);
  wire isPort  = isTx || isRx;
  wire swapOn  = (fsOn && isPort) ^ dbsOn;                          // R08 R16
  wire msbLane = !addr_q[0] ^ (fsOn && isPort);                     // R08
  wire allowWr = !(isRx && !mtOn);                                  // R10 R11
  wire allowRd = !(isTx && !mtOn);                                  // R10 R11

  wire [1:0] byteEn  = width_q ? 2'b11 : (msbLane ? 2'b10 : 2'b01);
  hmc_word_t wrWord;
  hmc_word_t beMask;
  hmc_word_t wrMask;
  hmc_word_t modeNew;
  hmc_word_t modeRead;
  hmc_word_t rdWord;
  hmc_word_t rdOut;

  assign wrWord  = width_q ? (swapOn ? swapBytes(dataS) : dataS) : {dataS[7:0], dataS[7:0]};
  assign beMask  = {{8{byteEn[1]}}, {8{byteEn[0]}}};
  assign wrMask  = `HMC_WR_MASK & beMask;                           // R18
  assign modeNew = (mode_q & ~wrMask) | (wrWord & wrMask);
  assign modeRead = (mode_q & `HMC_WR_MASK) | {width_q, pause_q, 14'h0000}; // R18
  assign rdWord  = isMode ? modeRead : (allowRd ? coreRdData : 16'h0000);
  assign rdOut   = width_q ? (swapOn ? swapBytes(rdWord) : rdWord)
                           : {8'h00, (msbLane ? rdWord[15:8] : rdWord[7:0])};

  wire doWrite   = (state_q == ST_WRITE) && fetch;
  wire modeWrite = doWrite && isMode && (srstCnt_q == 4'h0);
  wire coreWrite = doWrite && !isMode && allowWr;
  wire srstLast  = srstCnt_q == 4'h1;

  // ****************************************************************
  // bus width strap and pause flag
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strapDone_q <= 1'b0;
      width_q     <= 1'b0;
      pause_q     <= 1'b0;
    end else begin
      pause_q <= pauseFrameRx;                                       // R02
      if (!strapDone_q) begin
        strapDone_q <= 1'b1;
        width_q     <= strapS;                                       // R01
      end
    end
  end

  // ****************************************************************
  // mode word and soft reset
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q    <= `HMC_MODE_RESET;                                  // R13
      srstCnt_q <= 4'h0;
    end else if (srstLast) begin
      mode_q    <= `HMC_MODE_RESET;                                  // R09 R13
      srstCnt_q <= 4'h0;
    end else if (srstCnt_q != 4'h0) begin
      srstCnt_q <= srstCnt_q - 4'h1;
    end else if (modeWrite) begin
      mode_q <= modeNew;
      if (modeNew[`HMC_BIT_RST]) begin
        srstCnt_q <= `HMC_SRST_CYCLES;                               // R09
      end
    end
  end

  // ****************************************************************
  // host bus sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      csNPrev_q <= 1'b1;
      addr_q    <= 16'h0000;
      rdPend_q  <= 1'b0;
      holdCnt_q <= 2'h0;
    end else begin
      csNPrev_q <= csNS;
      rdPend_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (csFall && !wrNS) begin
            addr_q  <= addrS;
            state_q <= ST_WRITE;
          end else if (csFall && !rdNS) begin
            addr_q   <= addrS;
            rdPend_q <= 1'b1;
            state_q  <= ST_READ;
          end
        end
        ST_WRITE: begin
          if (fetch) begin
            state_q <= csNS ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (csNS) begin
            state_q <= ST_IDLE;
          end
        end
        ST_READ: begin
          if (csRise) begin
            holdCnt_q <= `HMC_HOLD_CYCLES;                           // R06
            state_q   <= rdhOn ? ST_HOLD : ST_IDLE;                  // R06
          end
        end
        ST_HOLD: begin
          holdCnt_q <= holdCnt_q - 2'h1;
          if (holdCnt_q == 2'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // host data pins
  // ****************************************************************
  wire driveNext = ((state_q == ST_IDLE) && csFall && wrNS && !rdNS)
                || ((state_q == ST_READ) && !(csRise && !rdhOn))
                || ((state_q == ST_HOLD) && (holdCnt_q != 2'h1));    // R06

  // core answers one cycle after its strobe, so take the word a cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hostDataOut <= 16'h0000;
      hostDataOe  <= 1'b0;
      rdTake_q    <= 1'b0;
    end else begin
      hostDataOe <= driveNext;
      rdTake_q   <= rdPend_q;
      if (rdTake_q) begin
        hostDataOut <= rdOut;
      end
    end
  end

  // ****************************************************************
  // core side strobes
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreWrStb     <= 1'b0;
      coreRdStb     <= 1'b0;
      coreAddr      <= 16'h0000;
      coreWrData    <= 16'h0000;
      coreByteEn    <= 2'b00;
      coreSoftReset <= 1'b0;
    end else begin
      coreWrStb     <= coreWrite;                                    // R04 R10
      coreRdStb     <= (state_q == ST_IDLE) && csFall && wrNS && !rdNS
                       && !isModeAddr(addrS)
                       && !(isPortAddr(addrS, `HMC_TX_PORT_OFS) && !mtOn);
      coreSoftReset <= (modeWrite && modeNew[`HMC_BIT_RST])
                       || ((srstCnt_q != 4'h0) && !srstLast);         // R09
      if (coreWrite) begin
        coreAddr   <= addr_q;
        coreWrData <= wrWord;
        coreByteEn <= byteEn;
      end else if ((state_q == ST_IDLE) && csFall) begin
        coreAddr   <= addrS;
        coreByteEn <= 2'b11;
      end
    end
  end

  // ****************************************************************
  // mode outputs
  // ****************************************************************
  assign txPause       = pause_q;                                    // R03
  assign pingBlock     = mode_q[`HMC_BIT_PB];                        // R14
  assign pppoeEnable   = mode_q[`HMC_BIT_PPP];                       // R15
  assign indirectMode  = mode_q[`HMC_BIT_IND];                       // R17
  assign memTestEnable = mode_q[`HMC_BIT_MT];                        // R11
  assign busWide       = width_q;                                    // R01
endmodule : hmc_mode_ctrl

`default_nettype wire

// [hmc_defs.svh]
/*
 * Constants of the host mode control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the block's top module.
 */
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define HMC_MODE_OFS      16'h8000
`define HMC_EVEN_MASK     16'hfffe
`define HMC_SOCK_BASE     16'h8200
`define HMC_SOCK_MASK     16'hfe00
`define HMC_PORT_MASK     6'h3e
`define HMC_TX_PORT_OFS   6'h2e
`define HMC_RX_PORT_OFS   6'h30

// ****************************************************************
// mode word fields
// ****************************************************************
`define HMC_BIT_WIDTH     15
`define HMC_BIT_PAUSE     14
`define HMC_BIT_WRF_HI    13
`define HMC_BIT_WRF_LO    11
`define HMC_BIT_RDH       10
`define HMC_BIT_FS        8
`define HMC_BIT_RST       7
`define HMC_BIT_MT        5
`define HMC_BIT_PB        4
`define HMC_BIT_PPP       3
`define HMC_BIT_DBS       2
`define HMC_BIT_IND       0
`define HMC_WR_MASK       16'h3dbd
`define HMC_MODE_RESET    16'h3800

// ****************************************************************
// timing
// ****************************************************************
`define HMC_HOLD_CYCLES   2'h2
`define HMC_SRST_CYCLES   4'h8

`endif

// [hmc_pkg.sv]
/*
 * Types shared by the host mode control block.
 * Assumes nothing beyond its own definitions.
 */
`default_nettype none

package hmc_pkg;
  typedef logic [15:0] hmc_word_t;
  typedef logic [2:0]  hmc_wrf_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_WAIT,
    ST_READ,
    ST_HOLD
  } hmc_state_t;
endpackage : hmc_pkg

`default_nettype wire

// [hmc_sync.sv]
/*
 * Two-flop synchroniser bank for the host pins.
 * Assumes every bit is an independent slow level.
 */
`default_nettype none

module hmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // core clock
  input  wire logic [W-1:0] d,      // asynchronous pins
  output var  logic [W-1:0] q       // synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : hmc_sync

`default_nettype wire

// [hmc_fetch.sv]
/*
 * Write data fetch timer: one pulse either a programmed number of cycles
 * after the start or at chip select release, whichever comes first.
 * Assumes start and csHigh are synchronised levels on clk.
 */
`default_nettype none

module hmc_fetch
  import hmc_pkg::*;
(
  input  wire logic              clk,    // core clock
  input  wire logic              rst_n,  // sync reset
  input  wire logic              start,  // chip select fell
  input  wire logic              csHigh, // chip select released
  input  wire hmc_pkg::hmc_wrf_t delay,  // programmed fetch delay
  output var  logic              fetch   // one-cycle capture pulse
);
  import hmc_pkg::*;

  logic     busy_q;
  hmc_wrf_t cnt_q;
  wire      due = busy_q && ((cnt_q == delay) || csHigh);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 3'h0;
      fetch  <= 1'b0;
    end else begin
      fetch <= due;                       // R04 R05
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= 3'h0;
      end else if (due) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule : hmc_fetch

`default_nettype wire

// [hmc_mode_ctrl_assertions.sv]
/*
 * Checker of the host mode control block, bound to its top module.
 * Assumes it sees only the top module's ports, all on clk.
 */
`default_nettype none

module hmc_mode_ctrl_assertions (
  input wire logic clk,           // core clock
  input wire logic rst_n,         // sync reset
  input wire logic hostCsN,       // host chip select
  input wire logic hostDataOe,    // data pins driven
  input wire logic pauseFrameRx,  // mac pause state
  input wire logic txPause,       // hold off transmit
  input wire logic coreWrStb,     // core write pulse
  input wire logic coreRdStb,     // core read pulse
  input wire logic coreSoftReset, // device soft reset
  input wire logic busWide,       // 16-bit host bus
  input wire logic pingBlock,     // no auto echo reply
  input wire logic pppoeEnable,   // pppoe mode
  input wire logic indirectMode,  // pointer addressing
  input wire logic memTestEnable  // memory test path
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_width_stable: assert property ($past(rst_n, 2) |-> $stable(busWide))
    else $error("bus width changed after reset");
  a_pause_on: assert property (pauseFrameRx |=> txPause)
    else $error("pause not followed");
  a_pause_off: assert property (!pauseFrameRx |=> !txPause)
    else $error("pause not released");
  a_wr_pulse: assert property (coreWrStb |=> !coreWrStb)
    else $error("write pulse too long");
  a_rd_drive: assert property (coreRdStb |-> hostDataOe)
    else $error("read without driving pins");
  a_oe_release: assert property ($rose(hostCsN) |-> ##[1:6] !hostDataOe)
    else $error("data pins not released");
  a_oe_hold: assert property ($rose(hostCsN) && hostDataOe |-> hostDataOe [*2])
    else $error("read data dropped early");
  a_srst_len: assert property ($rose(coreSoftReset) |-> coreSoftReset [*8] ##1 !coreSoftReset)
    else $error("soft reset length wrong");
  a_srst_clear: assert property ($fell(coreSoftReset) |->
    !pingBlock && !pppoeEnable && !indirectMode && !memTestEnable)
    else $error("mode not reloaded");
  a_rst_quiet: assert property ($rose(rst_n) |-> !coreSoftReset && !txPause && !pingBlock)
    else $error("outputs not reset");

  c_srst: cover property ($rose(coreSoftReset));
  c_write: cover property (coreWrStb);
  c_pause: cover property (txPause);
  c_hold: cover property ($rose(hostCsN) && hostDataOe);
endmodule : hmc_mode_ctrl_assertions

`default_nettype wire

// [hmc_core_model.sv]
/*
 * Core side model: answers a read strobe one cycle later.
 * Assumes the same clock as the block; idle data is inverted.
 */
`default_nettype none

module hmc_core_model (
  input  wire logic               clk,    // core clock
  input  wire logic               rdStb,  // read strobe
  output var  hmc_pkg::hmc_word_t rdData  // answer, next cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  import hmc_pkg::*;
  // inverse pattern when not answering
  always_ff @(posedge clk) begin
    rdData <= rdStb ? 16'h1234 : 16'hedcb;
  end
endmodule : hmc_core_model

`default_nettype wire

// [host_mode_control_test.sv]
/*
 * Testbench of the host mode control block: host bus tasks, scenarios.
 * Assumes design, core model and checker compiled before it.
 */
`default_nettype none

module host_mode_control_test import hmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic      clk, rst_n, csN, wrN, rdN, strap, pause;
  logic      oe, cws, crs, srst, txp, pb, ppp, address_via_pointer_select, mt, wide;
  logic [1:0] be;
  hmc_word_t addr, din, dout, crd, cadr, cwd, lastWr, v;
  int        err_count = 0, num_checks = 0, wrCnt = 0, rdCnt = 0, srstCnt = 0;

  hmc_mode_ctrl u_hmc_mode_ctrl (.clk(clk), .rst_n(rst_n), .hostCsN(csN), .hostWrN(wrN),
    .hostRdN(rdN), .hostAddr(addr), .hostDataIn(din), .hostDataOut(dout), .hostDataOe(oe),
    .wideBusStrap(strap), .pauseFrameRx(pause), .coreRdData(crd), .coreWrStb(cws),
    .coreRdStb(crs), .coreAddr(cadr), .coreWrData(cwd), .coreByteEn(be), .coreSoftReset(srst),
    .txPause(txp), .pingBlock(pb), .pppoeEnable(ppp), .indirectMode(address_via_pointer_select),
    .memTestEnable(mt), .busWide(wide));
  hmc_core_model u_hmc_core_model (.clk(clk), .rdStb(crs), .rdData(crd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cws === 1'b1) begin
      wrCnt++;
      lastWr = cwd;
    end
    if (crs === 1'b1) rdCnt++;
    if (srst === 1'b1) srstCnt++;
  end

  // ****************************************************************
  // host bus tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input hmc_word_t g, input hmc_word_t e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic reset(input logic s);
    strap = s;
    rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick(4);
  endtask : reset

  task automatic wr(input hmc_word_t a, input hmc_word_t d, input int hold, output int lat);
    lat = 0;
    addr = a;
    din = d;
    wrN = 1'b0;
    csN = 1'b0;
    for (int i = 1; i <= hold; i++) begin
      tick(1);
      if (cws === 1'b1 && lat == 0) lat = i;
    end
    csN = 1'b1;
    wrN = 1'b1;
    tick(8);
  endtask : wr

  task automatic rd(input hmc_word_t a, output hmc_word_t d, output int n);
    int k;
    k = 0;
    n = 0;
    addr = a;
    rdN = 1'b0;
    csN = 1'b0;
    while (oe !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    tick(2);
    d = dout;
    csN = 1'b1;
    rdN = 1'b1;
    while (oe !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    if (k == 20 || n == 20) begin
      err_count++;
      summarize();
    end
    tick(2);
  endtask : rd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    int l0, l7, n0, n1, c0;
    {csN, wrN, rdN, pause, rst_n} = 5'b11100;
    addr = 16'h0000;
    din = 16'h0000;
    reset(1'b1);
    rd(16'h8000, v, n0); chk("modeRst", v, 16'hb800);
    chk("wide", {15'h0, wide}, 16'h0001);
    wr(16'h8000, 16'hff7b, 14, l0);
    rd(16'h8000, v, n1); chk("modeRo", v, 16'hbd39);
    chk("flags", {12'h0, pb, ppp, address_via_pointer_select, mt}, 16'h000f);
    wr(16'h8000, 16'h0000, 14, l0);
    rd(16'h8000, v, n0); chk("modeClr", v, 16'h8000);
    chk("hold", 16'(n1 - n0), 16'h0002);
    wr(16'h822e, 16'h1234, 14, l0); chk("txWr", lastWr, 16'h1234);
    chk("txAddr", cadr, 16'h822e);
    chk("txBe", {14'h0, be}, 16'h0003);
    wr(16'h8000, 16'h3800, 14, l7);
    wr(16'h822e, 16'h1234, 14, l7); chk("fetch", 16'(l7 - l0), 16'h0007);
    wr(16'h8000, 16'h3810, 2, l0); chk("early", {15'h0, pb}, 16'h0001);
    c0 = wrCnt;
    wr(16'h8230, 16'h5555, 14, l0); chk("rxWr", 16'(wrCnt - c0), 16'h0000);
    c0 = rdCnt;
    rd(16'h822e, v, n0); chk("txRd", v, 16'h0000);
    chk("txRdStb", 16'(rdCnt - c0), 16'h0000);
    rd(16'h8230, v, n0); chk("rxRd", v, 16'h1234);
    wr(16'h8000, 16'h3820, 14, l0);
    rd(16'h822e, v, n0); chk("mtRd", v, 16'h1234);
    c0 = wrCnt;
    wr(16'h8230, 16'h5555, 14, l0); chk("mtWr", 16'(wrCnt - c0), 16'h0001);
    wr(16'h8000, 16'h3900, 14, l0);
    wr(16'h822e, 16'h1234, 14, l0); chk("fsWr", lastWr, 16'h3412);
    rd(16'h8230, v, n0); chk("fsRd", v, 16'h3412);
    wr(16'h8000, 16'h3904, 14, l0);
    wr(16'h822e, 16'h1234, 14, l0); chk("bothWr", lastWr, 16'h1234);
    rd(16'h8000, v, n0); chk("dbsRd", v, 16'h04b9);
    pause = 1'b1;
    tick(2); chk("txp", {15'h0, txp}, 16'h0001);
    rd(16'h8000, v, n0); chk("pauseRd", v, 16'h04f9);
    pause = 1'b0;
    tick(2); chk("txpOff", {15'h0, txp}, 16'h0000);
    c0 = srstCnt;
    wr(16'h8000, 16'h8039, 14, l0);
    tick(12); chk("srstLen", 16'(srstCnt - c0), 16'h0008);
    rd(16'h8000, v, n0); chk("srstMode", v, 16'hb800);
    reset(1'b0);
    strap = 1'b1;
    rd(16'h8000, v, n0); chk("narrowHi", v, 16'h0038);
    rd(16'h8001, v, n0); chk("narrowLo", v, 16'h0000);
    wr(16'h8001, 16'h0004, 14, l0);
    rd(16'h8000, v, n0); chk("noSwap", v, 16'h0038);
    chk("strapHeld", {15'h0, wide}, 16'h0000);
    summarize();
  end
endmodule : host_mode_control_test

bind hmc_mode_ctrl hmc_mode_ctrl_assertions u_hmc_mode_ctrl_assertions (.clk, .rst_n, .hostCsN,
  .hostDataOe, .pauseFrameRx, .txPause, .coreWrStb, .coreRdStb, .coreSoftReset, .busWide,
  .pingBlock, .pppoeEnable, .indirectMode, .memTestEnable);

`default_nettype wire
